// ### rtl/rtcc_regs.sv
// Time, calendar and alarm registers with status flags behind APB
// Operation
// - Mode bit 0 picks 12 or 24 hours
// - Seconds and minutes accept BCD 0..59
// - Units in low nibble, tens above
// - Hours 1..12 or 0..23 by mode
// - Time bit 22 flags afternoon
// - Century accepts only BCD 20
// - Year accepts BCD 00..99
// - Month accepts BCD 01..12
// - Weekday 1..7, never drives date
// - Day of month accepts 01 up to the length of the month
// - Time alarm fields with enables 7,15,23
// - Alarm fields compare to BCD counters, hour to the 12-hour view in 12-hour mode
// - Date alarm enable 31, month 23
// - Status bit 0 grants time or calendar updates
// - Status bit 1 set on alarm match
// - Status bit 2 set per second tick
// - Status bit 3 on selected time event
// - Status bit 4 on selected calendar event
// - Clear register ones clear status flags
// - Illegal writes dropped, validity flag set
// - Time event codes minute,hour,midnight,noon
//
// Our own choices: register access over APB and the placing of the registers.
`timescale 1ns/100ps
`include "rtcc_defs.svh"

module rtcc_regs #(
	parameter int TICKS_PER_SEC = `RTCC_SEC_NS / `RTCC_CLK_NS
) (
	input  wire logic        mclk,
	input  wire logic        rst_b,
	input  wire logic        ce,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic             pslverr,
	output logic [31:0]      prdata
);
	import rtcc_pkg::*;

	rtcc_state_type st_ff;
	rtcc_state_type nxt_st;
	logic           tick;
	logic           wr;
	logic           mapped;
	logic [7:0]     hourView;
	logic           alarmHit;
	logic           secWrap;
	logic           minWrap;
	logic           dayWrap;
	logic           dateWrap;
	logic           monthWrap;

	// Range and digit check of a BCD byte
	function automatic logic bcdOk(input logic [7:0] v, input logic [7:0] lo,
		input logic [7:0] hi);
		return v[3:0] <= 4'd9 && v[7:4] <= 4'd9 && v >= lo && v <= hi;
	endfunction

	function automatic logic [7:0] bcdInc(input logic [7:0] v);
		return (v[3:0] == 4'd9) ? {v[7:4] + 4'd1, 4'd0} : v + 8'd1;
	endfunction

	function automatic logic [4:0] bcdToBin(input logic [7:0] v);
		return 5'({v[5:4], 3'b000} + {v[5:4], 1'b0} + {1'b0, v[3:0]});
	endfunction

	function automatic logic [7:0] binToBcd(input logic [4:0] b);
		logic [7:0] r;
		r = 8'(b);
		if (b >= 5'd20) begin
			r = {4'd2, 4'(b - 5'd20)};
		end else if (b >= 5'd10) begin
			r = {4'd1, 4'(b - 5'd10)};
		end
		return r;
	endfunction

	// Stored 24-hour BCD to {afternoon, 12-hour BCD}
	function automatic logic [7:0] hourTo12(input logic [7:0] h);
		logic [4:0] b;
		logic       pm;
		b = bcdToBin(h);
		pm = b >= 5'd12;
		if (pm) begin
			b = b - 5'd12;
		end
		if (b == 5'd0) begin
			b = 5'd12;
		end
		return {pm, 7'(binToBcd(b))};
	endfunction

	function automatic logic [7:0] hourTo24(input logic [7:0] h, input logic pm);
		logic [4:0] b;
		b = bcdToBin(h);
		if (b == 5'd12) begin
			b = 5'd0;
		end
		if (pm) begin
			b = b + 5'd12;
		end
		return binToBcd(b);
	endfunction

	function automatic logic [7:0] daysIn(input logic [7:0] m, input logic [7:0] y);
		logic leap;
		leap = y[4] ? (y[3:0] == 4'd2 || y[3:0] == 4'd6)
			: (y[3:0] == 4'd0 || y[3:0] == 4'd4 || y[3:0] == 4'd8);
		case (m)
			8'h02: return leap ? 8'h29 : 8'h28;
			8'h04, 8'h06, 8'h09, 8'h11: return 8'h30;
			default: return `RTCC_BCD_31;
		endcase
	endfunction

	// hour range follows the selected format
	function automatic logic hourOk(input logic [7:0] h, input logic pm, input logic m12);
		return m12 ? bcdOk(h, `RTCC_BCD_ONE, `RTCC_BCD_TWELVE)
			: (bcdOk(h, `RTCC_BCD_ZERO, `RTCC_BCD_23) && !pm);
	endfunction

	assign tick = ce && st_ff.presc == 32'(TICKS_PER_SEC - 1);
	assign wr = psel && penable && pwrite && ce;
	assign mapped = paddr inside {`RTCC_OFF_CTRL, `RTCC_OFF_MODE, `RTCC_OFF_TIME,
		`RTCC_OFF_CAL, `RTCC_OFF_TALR, `RTCC_OFF_CALR, `RTCC_OFF_STAT,
		`RTCC_OFF_SCLR, `RTCC_OFF_VALID};
	assign pready = ce;
	assign pslverr = psel && penable && !mapped;
	assign prdata = st_ff.rdata;

	assign hourView = st_ff.twelveHour ? hourTo12(st_ff.hour) : {1'b0, st_ff.hour[6:0]};

	assign alarmHit = (st_ff.aSecEn || st_ff.aMinEn || st_ff.aHourEn || st_ff.aDateEn
		|| st_ff.aMonthEn)
		&& (!st_ff.aSecEn || st_ff.aSec == st_ff.sec[6:0])
		&& (!st_ff.aMinEn || st_ff.aMin == st_ff.min[6:0])
		&& (!st_ff.aHourEn || st_ff.aHour == {hourView[7], hourView[5:0]})
		&& (!st_ff.aDateEn || st_ff.aDate == st_ff.date[5:0])
		&& (!st_ff.aMonthEn || st_ff.aMonth == st_ff.month[4:0]);

	assign secWrap = st_ff.sec == `RTCC_BCD_59;
	assign minWrap = secWrap && st_ff.min == `RTCC_BCD_59;
	assign dayWrap = minWrap && st_ff.hour == `RTCC_BCD_23;
	assign dateWrap = dayWrap && st_ff.date == daysIn(st_ff.month, st_ff.year);
	assign monthWrap = dateWrap && st_ff.month == `RTCC_BCD_TWELVE;

	always_comb begin
		logic [7:0] h;
		h = `RTCC_BCD_ZERO;
		nxt_st = st_ff;
		nxt_st.presc = tick ? 32'd0 : st_ff.presc + 32'd1;
		if (wr) begin
			case (paddr)
				`RTCC_OFF_CTRL: begin
					nxt_st.updTim = pwdata[0];
					nxt_st.updCal = pwdata[1];
					nxt_st.time_event_select = pwdata[9:8];
					nxt_st.calendar_event_select = pwdata[17:16];
				end
				`RTCC_OFF_MODE: begin
					nxt_st.twelveHour = pwdata[0];
				end
				`RTCC_OFF_TIME: begin
					if (st_ff.updTim && st_ff.upd == UPD_GRANT) begin
						h = {2'b00, pwdata[21:16]};
						if (bcdOk({1'b0, pwdata[6:0]}, `RTCC_BCD_ZERO, `RTCC_BCD_59)
							&& bcdOk({1'b0, pwdata[14:8]}, `RTCC_BCD_ZERO, `RTCC_BCD_59)
							&& hourOk(h, pwdata[`RTCC_AFTERNOON_INDICATOR_BIT], st_ff.twelveHour)) begin
							nxt_st.sec = {1'b0, pwdata[6:0]};
							nxt_st.min = {1'b0, pwdata[14:8]};
							nxt_st.hour = st_ff.twelveHour
								? hourTo24(h, pwdata[`RTCC_AFTERNOON_INDICATOR_BIT]) : h;
							nxt_st.invalid[`RTCC_NV_TIM] = 1'b0;
						end else begin
							nxt_st.invalid[`RTCC_NV_TIM] = 1'b1;
						end
					end
				end
				`RTCC_OFF_CAL: begin
					if ((st_ff.updCal || st_ff.updTim) && st_ff.upd == UPD_GRANT) begin
						if (pwdata[7:0] == `RTCC_BCD_CENTURY_VALUE
							&& bcdOk(pwdata[15:8], `RTCC_BCD_ZERO, `RTCC_BCD_99)
							&& bcdOk({3'b000, pwdata[20:16]}, `RTCC_BCD_ONE,
								`RTCC_BCD_TWELVE)
							&& pwdata[23:21] != 3'd0
							&& bcdOk({2'b00, pwdata[29:24]}, `RTCC_BCD_ONE,
								daysIn({3'b000, pwdata[20:16]}, pwdata[15:8]))) begin
							nxt_st.century_value = pwdata[7:0];
							nxt_st.year = pwdata[15:8];
							nxt_st.month = {3'b000, pwdata[20:16]};
							nxt_st.dow = pwdata[23:21];
							nxt_st.date = {2'b00, pwdata[29:24]};
							nxt_st.invalid[`RTCC_NV_CAL] = 1'b0;
						end else begin
							nxt_st.invalid[`RTCC_NV_CAL] = 1'b1;
						end
					end
				end
				`RTCC_OFF_TALR: begin
					if (bcdOk({1'b0, pwdata[6:0]}, `RTCC_BCD_ZERO, `RTCC_BCD_59)
						&& bcdOk({1'b0, pwdata[14:8]}, `RTCC_BCD_ZERO, `RTCC_BCD_59)
						&& hourOk({2'b00, pwdata[21:16]}, pwdata[`RTCC_AFTERNOON_INDICATOR_BIT],
							st_ff.twelveHour)) begin
						nxt_st.aSec = pwdata[6:0];
						nxt_st.aMin = pwdata[14:8];
						nxt_st.aHour = pwdata[22:16];
						nxt_st.aSecEn = pwdata[`RTCC_SS_MATCH_ENABLE_BIT];
						nxt_st.aMinEn = pwdata[`RTCC_MM_MATCH_ENABLE_BIT];
						nxt_st.aHourEn = pwdata[`RTCC_HH_MATCH_ENABLE_BIT];
						nxt_st.invalid[`RTCC_NV_TALR] = 1'b0;
					end else begin
						nxt_st.invalid[`RTCC_NV_TALR] = 1'b1;
					end
				end
				`RTCC_OFF_CALR: begin
					if (bcdOk({2'b00, pwdata[29:24]}, `RTCC_BCD_ONE, `RTCC_BCD_31)
						&& bcdOk({3'b000, pwdata[20:16]}, `RTCC_BCD_ONE,
							`RTCC_BCD_TWELVE)) begin
						nxt_st.aDate = pwdata[29:24];
						nxt_st.aMonth = pwdata[20:16];
						nxt_st.aDateEn = pwdata[`RTCC_DAY_OF_MONTH_MATCH_ENABLE_BIT];
						nxt_st.aMonthEn = pwdata[`RTCC_MONTH_MATCH_ENABLE_BIT];
						nxt_st.invalid[`RTCC_NV_CALR] = 1'b0;
					end else begin
						nxt_st.invalid[`RTCC_NV_CALR] = 1'b1;
					end
				end
				`RTCC_OFF_SCLR: begin
					nxt_st.flags = st_ff.flags & ~pwdata[4:0];
				end
				default: begin
				end
			endcase
		end
		case (st_ff.upd)
			UPD_RUN: begin
				if (tick && (st_ff.updTim || st_ff.updCal)) begin
					nxt_st.upd = UPD_GRANT;
					nxt_st.flags[`RTCC_F_ACK] = 1'b1;
				end
			end
			UPD_GRANT: begin
				if (!st_ff.updTim && !st_ff.updCal) begin
					nxt_st.upd = UPD_HOLD;
				end
			end
			UPD_HOLD: begin
				if (tick) begin
					nxt_st.upd = UPD_RUN;
				end
			end
			default: begin
				nxt_st.upd = UPD_RUN;
			end
		endcase
		if (tick) begin
			nxt_st.flags[`RTCC_F_SEC] = 1'b1;
			if (alarmHit) begin
				nxt_st.flags[`RTCC_F_ALR] = 1'b1;
			end
		end
		if (tick && !st_ff.updTim) begin
			nxt_st.sec = secWrap ? `RTCC_BCD_ZERO : bcdInc(st_ff.sec);
			if (secWrap) begin
				nxt_st.min = minWrap ? `RTCC_BCD_ZERO : bcdInc(st_ff.min);
			end
			if (minWrap) begin
				nxt_st.hour = dayWrap ? `RTCC_BCD_ZERO : bcdInc(st_ff.hour);
			end
			case (st_ff.time_event_select)
				`RTCC_TEV_MIN: nxt_st.flags[`RTCC_F_TIM] |= secWrap;
				`RTCC_TEV_HOUR: nxt_st.flags[`RTCC_F_TIM] |= minWrap;
				`RTCC_TEV_MIDN: nxt_st.flags[`RTCC_F_TIM] |= dayWrap;
				`RTCC_TEV_NOON: nxt_st.flags[`RTCC_F_TIM] |=
					minWrap && st_ff.hour == `RTCC_BCD_ELEVEN;
				default: begin
				end
			endcase
			if (!st_ff.updCal && dayWrap) begin
				nxt_st.dow = (st_ff.dow == `RTCC_DOW_MAX) ? 3'd1 : st_ff.dow + 3'd1;
				nxt_st.date = dateWrap ? `RTCC_BCD_ONE : bcdInc(st_ff.date);
				if (dateWrap) begin
					nxt_st.month = monthWrap ? `RTCC_BCD_ONE : bcdInc(st_ff.month);
				end
				if (monthWrap) begin
					nxt_st.year = (st_ff.year == `RTCC_BCD_99) ? `RTCC_BCD_ZERO
						: bcdInc(st_ff.year);
				end
				case (st_ff.calendar_event_select)
					`RTCC_CEV_WEEK: nxt_st.flags[`RTCC_F_CAL] |=
						st_ff.dow == `RTCC_DOW_MAX;
					`RTCC_CEV_MONTH: nxt_st.flags[`RTCC_F_CAL] |= dateWrap;
					`RTCC_CEV_YEAR: nxt_st.flags[`RTCC_F_CAL] |= monthWrap;
					default: begin
					end
				endcase
			end
		end
		if (psel && !penable && !pwrite && ce) begin
			case (paddr)
				`RTCC_OFF_CTRL: nxt_st.rdata = {14'h0, st_ff.calendar_event_select, 6'h0,
					st_ff.time_event_select, 6'h0, st_ff.updCal, st_ff.updTim};
				`RTCC_OFF_MODE: nxt_st.rdata = {31'h0, st_ff.twelveHour};
				`RTCC_OFF_TIME: nxt_st.rdata = {9'h0, hourView[7], hourView[5:0],
					1'b0, st_ff.min[6:0], 1'b0, st_ff.sec[6:0]};
				`RTCC_OFF_CAL: nxt_st.rdata = {2'b00, st_ff.date[5:0], st_ff.dow,
					st_ff.month[4:0], st_ff.year, 1'b0, st_ff.century_value[6:0]};
				`RTCC_OFF_TALR: nxt_st.rdata = {8'h0, st_ff.aHourEn, st_ff.aHour,
					st_ff.aMinEn, st_ff.aMin, st_ff.aSecEn, st_ff.aSec};
				`RTCC_OFF_CALR: nxt_st.rdata = {st_ff.aDateEn, 1'b0, st_ff.aDate,
					st_ff.aMonthEn, 2'b00, st_ff.aMonth, 16'h0};
				`RTCC_OFF_STAT: nxt_st.rdata = {27'h0, st_ff.flags};
				`RTCC_OFF_VALID: nxt_st.rdata = {28'h0, st_ff.invalid};
				default: nxt_st.rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			st_ff <= '0;
			st_ff.upd <= UPD_RUN;
			st_ff.dow <= `RTCC_RST_DOW;
			st_ff.date <= `RTCC_RST_DATE;
			st_ff.month <= `RTCC_RST_MONTH;
			st_ff.year <= `RTCC_RST_YEAR;
			st_ff.century_value <= `RTCC_RST_CENTURY_VALUE;
			st_ff.aDate <= `RTCC_RST_ADATE;
			st_ff.aMonth <= `RTCC_RST_AMONTH;
		end else if (ce) begin
			st_ff <= nxt_st;
		end
	end

	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);

	a_bad_sec_kept: assert property (wr && paddr == `RTCC_OFF_TIME && st_ff.updTim
		&& st_ff.upd == UPD_GRANT && !bcdOk({1'b0, pwdata[6:0]}, `RTCC_BCD_ZERO, `RTCC_BCD_59)
		|=> st_ff.invalid[`RTCC_NV_TIM] && st_ff.sec == $past(st_ff.sec))
		else $error("illegal seconds loaded");
	a_bad_century_value_kept: assert property (wr && paddr == `RTCC_OFF_CAL &&
		(st_ff.updCal || st_ff.updTim) && st_ff.upd == UPD_GRANT
		&& pwdata[7:0] != `RTCC_BCD_CENTURY_VALUE
		|=> st_ff.invalid[`RTCC_NV_CAL] && $stable(st_ff.century_value))
		else $error("illegal century loaded");
	a_flag_clear: assert property (wr && paddr == `RTCC_OFF_SCLR && pwdata[1] &&
		!(tick && alarmHit) |=> !st_ff.flags[`RTCC_F_ALR])
		else $error("alarm flag not cleared");
	a_alarm_sets: assert property (tick && alarmHit |=> st_ff.flags[`RTCC_F_ALR])
		else $error("alarm match lost");
	a_sec_flag: assert property (tick |=> st_ff.flags[`RTCC_F_SEC])
		else $error("second flag not set");
	a_ack_cause: assert property ($rose(st_ff.flags[`RTCC_F_ACK]) |->
		$past(st_ff.updTim || st_ff.updCal) && st_ff.upd == UPD_GRANT)
		else $error("grant without request");
	a_min_event: assert property (tick && !st_ff.updTim && secWrap &&
		st_ff.time_event_select == `RTCC_TEV_MIN |=> st_ff.flags[`RTCC_F_TIM])
		else $error("minute event lost");
	a_hour12_view: assert property (psel && !penable && !pwrite && ce &&
		paddr == `RTCC_OFF_TIME && st_ff.twelveHour
		|=> prdata[21:16] != 6'h00 && prdata[21:16] <= 6'h12)
		else $error("12-hour read out of range");
	a_stopped_time: assert property (st_ff.updTim && !wr |=> $stable(st_ff.sec))
		else $error("time ran during update");

	c_alarm: cover property (tick && alarmHit);
	c_grant: cover property ($rose(st_ff.flags[`RTCC_F_ACK]));
	c_day_wrap: cover property (tick && dayWrap && !st_ff.updTim);
	c_bad_write: cover property ($rose(st_ff.invalid[`RTCC_NV_TIM]));
endmodule

// ### rtl/rtcc_defs.svh
// Constants of the time, calendar and alarm register block
`ifndef RTCC_DEFS_SVH
`define RTCC_DEFS_SVH
`define RTCC_OFF_CTRL    8'h00
`define RTCC_OFF_MODE    8'h04
`define RTCC_OFF_TIME    8'h08
`define RTCC_OFF_CAL     8'h0C
`define RTCC_OFF_TALR    8'h10
`define RTCC_OFF_CALR    8'h14
`define RTCC_OFF_STAT    8'h18
`define RTCC_OFF_SCLR    8'h1C
`define RTCC_OFF_VALID   8'h2C
`define RTCC_F_ACK       0
`define RTCC_F_ALR       1
`define RTCC_F_SEC       2
`define RTCC_F_TIM       3
`define RTCC_F_CAL       4
`define RTCC_NV_TIM      0
`define RTCC_NV_CAL      1
`define RTCC_NV_TALR     2
`define RTCC_NV_CALR     3
`define RTCC_AFTERNOON_INDICATOR_BIT    22
`define RTCC_SS_MATCH_ENABLE_BIT   7
`define RTCC_MM_MATCH_ENABLE_BIT   15
`define RTCC_HH_MATCH_ENABLE_BIT  23
`define RTCC_DAY_OF_MONTH_MATCH_ENABLE_BIT  31
`define RTCC_MONTH_MATCH_ENABLE_BIT   23
`define RTCC_RST_DATE    8'h01
`define RTCC_RST_DOW     3'd1
`define RTCC_RST_MONTH   8'h01
`define RTCC_RST_YEAR    8'h07
`define RTCC_RST_CENTURY_VALUE    8'h20
`define RTCC_RST_ADATE   6'h01
`define RTCC_RST_AMONTH  5'h01
`define RTCC_BCD_ZERO    8'h00
`define RTCC_BCD_ONE     8'h01
`define RTCC_BCD_ELEVEN  8'h11
`define RTCC_BCD_TWELVE  8'h12
`define RTCC_BCD_23      8'h23
`define RTCC_BCD_59      8'h59
`define RTCC_BCD_99      8'h99
`define RTCC_BCD_31      8'h31
`define RTCC_BCD_CENTURY_VALUE    8'h20
`define RTCC_DOW_MAX     3'd7
`define RTCC_TEV_MIN     2'd0
`define RTCC_TEV_HOUR    2'd1
`define RTCC_TEV_MIDN    2'd2
`define RTCC_TEV_NOON    2'd3
`define RTCC_CEV_WEEK    2'd0
`define RTCC_CEV_MONTH   2'd1
`define RTCC_CEV_YEAR    2'd2
`define RTCC_SEC_NS      1000000000
`define RTCC_CLK_NS      10
`endif

// ### rtl/rtcc_pkg.sv
// Types of the time, calendar and alarm register block
package rtcc_pkg;
	typedef enum logic [2:0] {
		UPD_RUN   = 3'b001,
		UPD_GRANT = 3'b010,
		UPD_HOLD  = 3'b100
	} rtcc_upd_type;

	typedef struct packed {
		rtcc_upd_type upd;
		logic         updTim;
		logic         updCal;
		logic [1:0]   time_event_select;
		logic [1:0]   calendar_event_select;
		logic         twelveHour;
		logic [7:0]   sec;
		logic [7:0]   min;
		logic [7:0]   hour;
		logic [2:0]   dow;
		logic [7:0]   date;
		logic [7:0]   month;
		logic [7:0]   year;
		logic [7:0]   century_value;
		logic [6:0]   aSec;
		logic [6:0]   aMin;
		logic [6:0]   aHour;
		logic [5:0]   aDate;
		logic [4:0]   aMonth;
		logic         aSecEn;
		logic         aMinEn;
		logic         aHourEn;
		logic         aDateEn;
		logic         aMonthEn;
		logic [4:0]   flags;
		logic [3:0]   invalid;
		logic [31:0]  presc;
		logic [31:0]  rdata;
	} rtcc_state_type;
endpackage

// ### verification/rtcc_regs_tb.sv
// Self-checking bench of the time, calendar and alarm register block
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin numChecks++; if ((got) !== (ex)) begin badCount++; \
	$display("[FAIL] %s expected %h seen %h", nm, ex, got); end end

module testbench;
	import rtcc_pkg::*;
	localparam int TPS = 64;
	typedef struct {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] ex; logic er;} rtcc_row_type;
	typedef struct {logic [7:0] a; logic [31:0] g; logic [31:0] b; int v;} rtcc_bad_type;
	logic        mclk = 1'b0;
	logic        rst_b = 1'b0;
	logic        ce = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic        pready;
	logic        pslverr;
	logic [31:0] prdata;
	logic [31:0] rd;
	logic        err;
	int          badCount = 0;
	int          numChecks = 0;
	rtcc_row_type rows [11] = '{
		'{1'b0, 8'h18, 32'h0000_0000, 32'h0000_0000, 1'b0},
		'{1'b0, 8'h08, 32'h0000_0000, 32'h0000_0000, 1'b0},
		'{1'b0, 8'h0C, 32'h0000_0000, 32'h0121_0720, 1'b0},
		'{1'b0, 8'h14, 32'h0000_0000, 32'h0101_0000, 1'b0},
		'{1'b0, 8'h10, 32'h0000_0000, 32'h0000_0000, 1'b0},
		'{1'b0, 8'h04, 32'h0000_0000, 32'h0000_0000, 1'b0},
		'{1'b0, 8'h2C, 32'h0000_0000, 32'h0000_0000, 1'b0},
		'{1'b0, 8'h30, 32'h0000_0000, 32'h0000_0000, 1'b1},
		'{1'b1, 8'h04, 32'h0000_0001, 32'h0000_0000, 1'b0},
		'{1'b0, 8'h04, 32'h0000_0000, 32'h0000_0001, 1'b0},
		'{1'b1, 8'h04, 32'h0000_0000, 32'h0000_0000, 1'b0}
	};
	rtcc_bad_type bad [9] = '{
		'{8'h08, 32'h0023_5958, 32'h0000_0060, 0},
		'{8'h08, 32'h0023_5958, 32'h0000_5A00, 0},
		'{8'h08, 32'h0023_5958, 32'h0024_0000, 0},
		'{8'h08, 32'h0023_5958, 32'h0040_1000, 0},
		'{8'h0C, 32'h0121_0720, 32'h0121_0719, 1},
		'{8'h0C, 32'h0121_0720, 32'h0133_0720, 1},
		'{8'h0C, 32'h0121_0720, 32'h3221_0720, 1},
		'{8'h0C, 32'h0121_0720, 32'h0101_0720, 1},
		'{8'h14, 32'h0101_0000, 32'h0113_0000, 3}
	};

	always #5 mclk = ~mclk;

	rtcc_regs #(.TICKS_PER_SEC(TPS)) i_rtcc_regs (
		.mclk    (mclk),
		.rst_b   (rst_b),
		.ce      (ce),
		.psel    (psel),
		.penable (penable),
		.pwrite  (pwrite),
		.paddr   (paddr),
		.pwdata  (pwdata),
		.pready  (pready),
		.pslverr (pslverr),
		.prdata  (prdata)
	);

	task summarize;
		if (badCount == 0 && numChecks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		if (n >= 16) begin
			badCount++;
			summarize();
		end
		@(posedge mclk);
	endtask

	task automatic rdChk(input logic [7:0] a, input logic [31:0] ex, input string nm);
		apb(1'b0, a, 32'h0000_0000);
		`CHK(nm, ex, rd)
	endtask

	task automatic waitBit(input int b, input int lim);
		int n;
		n = 0;
		do begin
			apb(1'b0, 8'h18, 32'h0000_0000);
			n++;
		end while (rd[b] !== 1'b1 && n < lim);
		if (n >= lim) begin
			badCount++;
			summarize();
		end
	endtask

	initial begin
		repeat (5) @(posedge mclk);
		rst_b <= 1'b1;
		foreach (rows[i]) begin
			apb(rows[i].w, rows[i].a, rows[i].d);
			if (!rows[i].w) begin
				`CHK("register read", rows[i].ex, rd)
				`CHK("slave error", rows[i].er, err)
			end
		end
		apb(1'b1, 8'h00, 32'h0000_0003);
		waitBit(0, 64);
		`CHK("update granted", 1'b1, rd[0])
		apb(1'b1, 8'h1C, 32'h0000_0001);
		apb(1'b1, 8'h08, 32'h0023_5958);
		rdChk(8'h08, 32'h0023_5958, "time 24h");
		apb(1'b1, 8'h04, 32'h0000_0001);
		rdChk(8'h08, 32'h0051_5958, "time 12h");
		apb(1'b1, 8'h08, 32'h0000_0000);
		rdChk(8'h2C, 32'h0000_0001, "hour zero in 12h");
		apb(1'b1, 8'h04, 32'h0000_0000);
		foreach (bad[i]) begin
			apb(1'b1, bad[i].a, bad[i].g);
			apb(1'b1, bad[i].a, bad[i].b);
			rdChk(8'h2C, 32'h0000_0001 << bad[i].v, "validity flag");
			rdChk(bad[i].a, bad[i].g, "value kept");
			apb(1'b1, bad[i].a, bad[i].g);
			rdChk(8'h2C, 32'h0000_0000, "validity cleared");
		end
		apb(1'b1, 8'h0C, 32'h31F2_9920);
		apb(1'b1, 8'h08, 32'h0023_5958);
		rdChk(8'h0C, 32'h31F2_9920, "calendar limits");
		rdChk(8'h2C, 32'h0000_0000, "validity clear");
		apb(1'b1, 8'h1C, 32'h0000_001F);
		apb(1'b1, 8'h00, 32'h0002_0200);
		waitBit(4, 4 * TPS);
		rdChk(8'h0C, 32'h0121_0020, "new year");
		apb(1'b0, 8'h18, 32'h0000_0000);
		`CHK("calendar event", 1'b1, rd[4])
		`CHK("midnight event", 1'b1, rd[3])
		`CHK("second flag", 1'b1, rd[2])
		`CHK("no alarm", 1'b0, rd[1])
		apb(1'b1, 8'h1C, 32'h0000_0000);
		apb(1'b0, 8'h18, 32'h0000_0000);
		`CHK("clear by zeros", 2'b11, rd[4:3])
		apb(1'b1, 8'h1C, 32'h0000_0018);
		apb(1'b0, 8'h18, 32'h0000_0000);
		`CHK("clear by ones", 2'b00, rd[4:3])
		apb(1'b1, 8'h14, 32'h0181_0000);
		apb(1'b1, 8'h10, 32'h0000_81B0);
		repeat (40 * TPS) @(posedge mclk);
		apb(1'b0, 8'h18, 32'h0000_0000);
		`CHK("minute blocks alarm", 1'b0, rd[1])
		apb(1'b1, 8'h10, 32'h0000_01B0);
		waitBit(1, 30 * TPS);
		// Clock enable low freezes counting and the bus
		ce <= 1'b0;
		repeat (4 * TPS) @(posedge mclk);
		`CHK("ready held low", 1'b0, pready)
		ce <= 1'b1;
		apb(1'b0, 8'h08, 32'h0000_0000);
		`CHK("alarm minute", 8'h01, rd[15:8])
		`CHK("alarm second tens", 4'h3, rd[7:4])
		`CHK("frozen seconds", 8'h31, rd[7:0])
		// Three-step change of the second alarm
		apb(1'b1, 8'h10, 32'h0000_0130);
		apb(1'b1, 8'h10, 32'h0000_0145);
		apb(1'b1, 8'h10, 32'h0000_01C5);
		apb(1'b1, 8'h1C, 32'h0000_0002);
		waitBit(1, 30 * TPS);
		apb(1'b0, 8'h08, 32'h0000_0000);
		`CHK("changed alarm second", 8'h46, rd[7:0])
		// Mid-run reset, then noon in 12-hour mode
		rst_b <= 1'b0;
		repeat (2) @(posedge mclk);
		rst_b <= 1'b1;
		rdChk(8'h0C, 32'h0121_0720, "calendar after reset");
		rdChk(8'h18, 32'h0000_0000, "status after reset");
		apb(1'b1, 8'h00, 32'h0000_0001);
		waitBit(0, 64);
		apb(1'b1, 8'h04, 32'h0000_0001);
		apb(1'b1, 8'h08, 32'h0011_5958);
		apb(1'b1, 8'h1C, 32'h0000_001F);
		apb(1'b1, 8'h00, 32'h0000_0300);
		waitBit(3, 4 * TPS);
		`CHK("no week event", 1'b0, rd[4])
		apb(1'b0, 8'h08, 32'h0000_0000);
		`CHK("noon in 12h", 7'h52, rd[22:16])
		summarize();
	end
endmodule
